// ### src/dpp_pkg.sv
// Summary of operation
// - pin low selects parallel, high selects serial
// - parallel mode takes word from eight inputs
// - load window high follows inputs, falling holds
// - host without gating ties load window high
// - serial shifting only with window high, old delay
// - serial data msb first, sampled rising clock
// - window falling in serial activates shift contents
// - previous contents shift out msb first
// - cascade sends eight bits per device
// - readback starts: window rises, clock low
// - readback presents bit 7, rewrites each rise
// - host restores with eight pulses, looped data
// - host data driver released during readback
// - restored value leaves active delay unchanged unless last load was parallel
// - host waits settling time after each change
// - select 0: delayed copy plus reference copy
// - select 1: one-shot output, width from word
// - no new trigger until one-shot ended
// - select 1: delayed output is inverted copy
package dpp_pkg;
	localparam int WORD_W = 8;
	localparam int HIST_DEPTH = 256;
	localparam int REF_TAP = 1;
	localparam int PIN_Q = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_D = 2;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCLK_HALF_NS = 100;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_WAIT_NS = 500;
	localparam int SETTLE_WAIT_CYC =
		(SETTLE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAR_HOLD_CYC = 4;
	localparam int MODE_WAIT_CYC = 4;
	localparam logic [1:0] CMD_PAR_WRITE = 2'h0;
	localparam logic [1:0] CMD_SER_WRITE = 2'h1;
	localparam logic [1:0] CMD_SER_READ = 2'h2;
	localparam logic [7:0] ACTIVE_RESET = 8'h00;
endpackage : dpp_pkg

// ### src/dpp_if.sv
`timescale 1ns/10ps
interface dpp_if;
	logic [7:0] host_pin_o;
	logic [7:0] host_pin_oe;
	logic       dev_q_o;
	logic       dev_q_oe;
	logic       prog_serial_sel;
	logic       load_window;
	logic       output_function_select;
	logic [7:0] pin;

	////////////////////////////////////////////////////////////////////
	// wire levels; an undriven d pin sees q through the feedback resistor
	genvar b;
	for (b = 0; b < 8; b++) begin : g_pin
		if (b == dpp_pkg::PIN_Q || b == dpp_pkg::PIN_D) begin : g_fb
			assign pin[b] = host_pin_oe[b] ? host_pin_o[b] :
				(dev_q_oe ? dev_q_o : 1'b0);
		end else begin : g_plain
			assign pin[b] = host_pin_oe[b] ? host_pin_o[b] : 1'b0;
		end
	end

	modport device (
		input  pin,
		input  prog_serial_sel,
		input  load_window,
		input  output_function_select,
		output dev_q_o,
		output dev_q_oe
	);
	modport host (
		input  pin,
		output host_pin_o,
		output host_pin_oe,
		output prog_serial_sel,
		output load_window,
		output output_function_select
	);
endinterface : dpp_if

// ### src/dpp_device.sv
`timescale 1ns/10ps
module dpp_device (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	dpp_if.device           link,
	input  wire logic       timing_in,
	output logic            delayed_out,
	output logic            shared_out,
	output logic [7:0]      active_word
);
	typedef struct packed {
		logic [7:0]   pin_s1;
		logic [7:0]   pin_s2;
		logic         sel_s1;
		logic         sel_s2;
		logic         lw_s1;
		logic         lw_s2;
		logic         ofs_s1;
		logic         ofs_s2;
		logic         tin_s1;
		logic         tin_s2;
		logic         sclk_prev;
		logic         lw_prev;
		logic         in_prev;
		logic [7:0]   shift;
		logic [7:0]   active;
		logic [255:0] hist;
		logic         shot_busy;
		logic [7:0]   shot_cnt;
		logic         delayed_out;
		logic         shared_out;
		logic         q_o;
		logic         q_oe;
	} dpp_dev_state_t;

	dpp_dev_state_t state_reg;
	dpp_dev_state_t state_next;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		// every pin is asynchronous here, so two flops before use
		state_next.pin_s1 = link.pin;
		state_next.pin_s2 = state_reg.pin_s1;
		state_next.sel_s1 = link.prog_serial_sel;
		state_next.sel_s2 = state_reg.sel_s1;
		state_next.lw_s1 = link.load_window;
		state_next.lw_s2 = state_reg.lw_s1;
		state_next.ofs_s1 = link.output_function_select;
		state_next.ofs_s2 = state_reg.ofs_s1;
		state_next.tin_s1 = timing_in;
		state_next.tin_s2 = state_reg.tin_s1;
		state_next.sclk_prev = state_reg.pin_s2[dpp_pkg::PIN_SCLK];
		state_next.lw_prev = state_reg.lw_s2;
		state_next.in_prev = state_reg.tin_s2;

		if (!state_reg.sel_s2) begin
			if (state_reg.lw_s2) begin
				state_next.active = state_reg.pin_s2;
			end
		end else begin
			// shifting touches only the shift register
			if (state_reg.lw_s2 && state_reg.pin_s2[dpp_pkg::PIN_SCLK] &&
					!state_reg.sclk_prev) begin
				state_next.shift = {state_reg.shift[6:0],
					state_reg.pin_s2[dpp_pkg::PIN_D]};
			end
			// a fully restored read reloads the same value
			if (!state_reg.lw_s2 && state_reg.lw_prev) begin
				state_next.active = state_reg.shift;
			end
		end
		// q always shows the msb, so a read sees bit 7 first
		state_next.q_o = state_next.shift[7];
		state_next.q_oe = state_reg.sel_s2;

		// the delay line is a tap history; step zero is the sync latency
		state_next.hist = {state_reg.hist[254:0], state_reg.tin_s2};
		if (state_reg.ofs_s2) begin
			state_next.delayed_out = ~state_reg.hist[state_reg.active];
		end else begin
			state_next.delayed_out = state_reg.hist[state_reg.active];
		end

		// one-shot ignores edges while running: not retriggerable
		if (state_reg.shot_busy) begin
			state_next.shot_cnt = state_reg.shot_cnt - 8'h01;
			if (state_reg.shot_cnt == 8'h01) begin
				state_next.shot_busy = 1'b0;
			end
		end else if (state_reg.tin_s2 && !state_reg.in_prev &&
				state_reg.active != 8'h00) begin
			state_next.shot_busy = 1'b1;
			state_next.shot_cnt = state_reg.active;
		end
		if (state_reg.ofs_s2) begin
			state_next.shared_out = state_next.shot_busy;
		end else begin
			state_next.shared_out = state_reg.hist[dpp_pkg::REF_TAP];
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.active <= dpp_pkg::ACTIVE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign delayed_out = state_reg.delayed_out;
	assign shared_out = state_reg.shared_out;
	assign active_word = state_reg.active;
	assign link.dev_q_o = state_reg.q_o;
	assign link.dev_q_oe = state_reg.q_oe;
endmodule : dpp_device

// ### src/dpp_host.sv
`timescale 1ns/10ps
module dpp_host (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	dpp_if.host             link,
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_kind,
	input  wire logic [7:0] cmd_word,
	input  wire logic       ofs_req,
	output logic            cmd_ready,
	output logic            done,
	output logic [7:0]      read_word
);
	typedef enum logic [8:0] {
		H_IDLE     = 9'h001,
		H_MODE     = 9'h002,
		H_PAR_LOAD = 9'h004,
		H_PAR_HOLD = 9'h008,
		H_SER_OPEN = 9'h010,
		H_SER_LOW  = 9'h020,
		H_SER_HIGH = 9'h040,
		H_CLOSE    = 9'h080,
		H_SETTLE   = 9'h100
	} dpp_host_state_t;

	typedef struct packed {
		dpp_host_state_t st;
		logic [7:0]      cnt;
		logic [3:0]      bits;
		logic [1:0]      kind;
		logic [7:0]      tx;
		logic [7:0]      rx;
		logic            q_s1;
		logic            q_s2;
		logic [7:0]      pin_o;
		logic [7:0]      pin_oe;
		logic            sel;
		logic            lw;
		logic            ofs;
		logic            ready;
		logic            done;
	} dpp_host_reg_t;

	dpp_host_reg_t h_reg;
	dpp_host_reg_t h_next;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		h_next = h_reg;
		h_next.q_s1 = link.pin[dpp_pkg::PIN_Q];
		h_next.q_s2 = h_reg.q_s1;
		h_next.ofs = ofs_req;
		h_next.done = 1'b0;
		if (h_reg.cnt != 8'h00) begin
			h_next.cnt = h_reg.cnt - 8'h01;
		end
		unique case (h_reg.st)
			H_IDLE: begin
				if (cmd_valid && cmd_kind != 2'h3) begin
					h_next.kind = cmd_kind;
					h_next.tx = cmd_word;
					h_next.ready = 1'b0;
					h_next.lw = 1'b0;
					h_next.sel = (cmd_kind != dpp_pkg::CMD_PAR_WRITE);
					h_next.cnt = 8'(dpp_pkg::MODE_WAIT_CYC);
					h_next.st = H_MODE;
				end
			end
			H_MODE: begin
				if (h_reg.cnt == 8'h00) begin
					h_next.lw = 1'b1;
					if (h_reg.kind == dpp_pkg::CMD_PAR_WRITE) begin
						h_next.pin_o = h_reg.tx;
						h_next.pin_oe = 8'hFF;
						h_next.cnt = 8'(dpp_pkg::PAR_HOLD_CYC);
						h_next.st = H_PAR_LOAD;
					end else begin
						// clock held low while the window opens
						h_next.pin_o = 8'h00;
						h_next.pin_oe = 8'hFB;
						if (h_reg.kind == dpp_pkg::CMD_SER_WRITE) begin
							h_next.pin_oe = 8'hFE;
						end
						h_next.pin_oe[dpp_pkg::PIN_Q] = 1'b0;
						h_next.bits = 4'h8;
						h_next.cnt = 8'(dpp_pkg::SCLK_HALF_CYC);
						h_next.st = H_SER_OPEN;
					end
				end
			end
			H_PAR_LOAD: begin
				if (h_reg.cnt == 8'h00) begin
					h_next.lw = 1'b0;
					h_next.cnt = 8'(dpp_pkg::PAR_HOLD_CYC);
					h_next.st = H_PAR_HOLD;
				end
			end
			H_PAR_HOLD: begin
				// data kept past the window fall to cover sync skew
				if (h_reg.cnt == 8'h00) begin
					h_next.pin_oe = 8'h00;
					h_next.cnt = 8'(dpp_pkg::SETTLE_WAIT_CYC);
					h_next.st = H_SETTLE;
				end
			end
			H_SER_OPEN: begin
				if (h_reg.cnt == 8'h00) begin
					h_next.pin_o[dpp_pkg::PIN_D] = h_reg.tx[7];
					h_next.cnt = 8'(dpp_pkg::SCLK_HALF_CYC);
					h_next.st = H_SER_LOW;
				end
			end
			H_SER_LOW: begin
				if (h_reg.cnt == 8'h00) begin
					h_next.rx = {h_reg.rx[6:0], h_reg.q_s2};
					h_next.pin_o[dpp_pkg::PIN_SCLK] = 1'b1;
					h_next.cnt = 8'(dpp_pkg::SCLK_HALF_CYC);
					h_next.st = H_SER_HIGH;
				end
			end
			H_SER_HIGH: begin
				if (h_reg.cnt == 8'h00) begin
					h_next.pin_o[dpp_pkg::PIN_SCLK] = 1'b0;
					h_next.tx = {h_reg.tx[6:0], 1'b0};
					h_next.pin_o[dpp_pkg::PIN_D] = h_reg.tx[6];
					h_next.bits = h_reg.bits - 4'h1;
					h_next.cnt = 8'(dpp_pkg::SCLK_HALF_CYC);
					h_next.st = (h_reg.bits == 4'h1) ? H_CLOSE : H_SER_LOW;
				end
			end
			H_CLOSE: begin
				if (h_reg.cnt == 8'h00) begin
					h_next.lw = 1'b0;
					h_next.pin_oe = 8'h00;
					h_next.cnt = 8'(dpp_pkg::SETTLE_WAIT_CYC);
					h_next.st = H_SETTLE;
				end
			end
			H_SETTLE: begin
				// restored reads change nothing unless the last load was parallel, but one path is simpler
				if (h_reg.cnt == 8'h00) begin
					h_next.done = 1'b1;
					h_next.ready = 1'b1;
					h_next.st = H_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			h_reg <= '0;
			h_reg.st <= H_IDLE;
			h_reg.ready <= 1'b1;
		end else begin
			h_reg <= h_next;
		end
	end

	assign cmd_ready = h_reg.ready;
	assign done = h_reg.done;
	assign read_word = h_reg.rx;
	assign link.host_pin_o = h_reg.pin_o;
	assign link.host_pin_oe = h_reg.pin_oe;
	assign link.prog_serial_sel = h_reg.sel;
	assign link.load_window = h_reg.lw;
	assign link.output_function_select = h_reg.ofs;
endmodule : dpp_host

// ### test/dpp_checker.sv
`timescale 1ns/10ps
module dpp_checker (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic [7:0] host_pin_o,
	input wire logic [7:0] host_pin_oe,
	input wire logic       dev_q_oe,
	input wire logic       prog_serial_sel,
	input wire logic       load_window
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////
	// four cycles covers the two-flop sync of the select pin
	a_qoe_serial_on: assert property (
		prog_serial_sel [*4] |-> dev_q_oe)
		else $error("q driver off in serial mode");
	a_qoe_par_off: assert property (
		!prog_serial_sel [*4] |-> !dev_q_oe)
		else $error("q driver enabled in parallel mode");
	a_sclk_in_win: assert property (
		prog_serial_sel && $rose(host_pin_o[1]) |-> load_window)
		else $error("serial clock rose outside window");
	a_read_start: assert property (
		prog_serial_sel && $rose(load_window) |-> !host_pin_o[1])
		else $error("window opened with serial clock high");
	a_data_stable: assert property (
		prog_serial_sel && $rose(host_pin_o[1]) |-> $stable(host_pin_o[2]))
		else $error("data moved at serial clock rise");
	a_sclk_spacing: assert property (
		prog_serial_sel && $rose(host_pin_o[1]) |=> host_pin_o[1] [*3])
		else $error("serial clock high too short");
	a_q_released: assert property (
		prog_serial_sel && load_window |-> !host_pin_oe[0])
		else $error("host drives q pin in window");
	a_close_clean: assert property (
		prog_serial_sel && $fell(load_window)
		|-> host_pin_oe[2:0] == 3'h0 && !host_pin_o[1])
		else $error("serial pins still driven at close");
endmodule : dpp_checker

// ### test/delay_element_program_port_tb.sv
`timescale 1ns/10ps
module delay_element_program_port_tb;
	logic       core_clk;
	logic       reset_n;
	logic       cmd_valid;
	logic [1:0] cmd_kind;
	logic [7:0] cmd_word;
	logic       ofs_req;
	logic       timing_in;
	logic       cmd_ready;
	logic       done;
	logic [7:0] read_word;
	logic       delayed_out;
	logic       shared_out;
	logic [7:0] active_word;
	int         miscompares;
	int         cmp_count;
	int         cycles;
	int         hi;
	dpp_if lnk ();
	dpp_host i_dpp_host (.core_clk(core_clk), .reset_n(reset_n),
		.link(lnk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_word(cmd_word), .ofs_req(ofs_req),
		.cmd_ready(cmd_ready), .done(done), .read_word(read_word));
	dpp_device i_dpp_device (.core_clk(core_clk), .reset_n(reset_n),
		.link(lnk), .timing_in(timing_in), .delayed_out(delayed_out),
		.shared_out(shared_out), .active_word(active_word));
	dpp_checker i_dpp_checker (.core_clk(core_clk), .reset_n(reset_n),
		.host_pin_o(lnk.host_pin_o), .host_pin_oe(lnk.host_pin_oe),
		.dev_q_oe(lnk.dev_q_oe), .prog_serial_sel(lnk.prog_serial_sel),
		.load_window(lnk.load_window));
	////////////////////////////////////////////////////////////////////
	always #12.5 core_clk = ~core_clk;
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// old word must hold mid-transfer, before the window closes
	task automatic run(input logic [1:0] k, input logic [7:0] w);
		logic [7:0] old;
		old = active_word;
		repeat (2) @(posedge core_clk);
		#1;
		cmd_valid = 1'h1;
		cmd_kind = k;
		cmd_word = w;
		@(posedge core_clk);
		#1;
		cmd_valid = 1'h0;
		if (k != 2'h0) begin
			repeat (60) @(posedge core_clk);
			#1;
			chk("active mid", active_word, old);
		end
		// a lost done is left to the cycle ceiling, which fails the run
		while (done !== 1'h1) begin
			@(posedge core_clk);
			#1;
		end
	endtask : run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'h0;
		reset_n = 1'h0;
		cmd_valid = 1'h0;
		cmd_kind = 2'h0;
		cmd_word = 8'h00;
		ofs_req = 1'h0;
		timing_in = 1'h0;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (3) @(posedge core_clk);
		#1;
		reset_n = 1'h1;
		chk("reset", active_word, 8'h00);
		run(2'h0, 8'hA5);
		chk("par", active_word, 8'hA5);
		run(2'h1, 8'h3C);
		chk("ser", active_word, 8'h3C);
		run(2'h2, 8'h00);
		chk("read", read_word, 8'h3C);
		chk("kept", active_word, 8'h3C);
		run(2'h1, 8'h81);
		run(2'h2, 8'h00);
		chk("read2", read_word, 8'h81);
		run(2'h0, 8'h06);
		chk("par2", active_word, 8'h06);
		@(posedge core_clk);
		#1;
		cmd_valid = 1'h1;
		cmd_kind = 2'h3;
		repeat (20) @(posedge core_clk);
		#1;
		cmd_valid = 1'h0;
		chk("ignored", {cmd_ready, active_word[6:0]}, 8'h86);
		timing_in = 1'h1;
		// reference leads delayed by the word less the reference tap
		hi = 0;
		repeat (30) begin
			@(posedge core_clk);
			#1;
			if (shared_out === 1'h1 && delayed_out === 1'h0) hi++;
		end
		chk("dly", {6'h00, delayed_out, shared_out}, 8'h03);
		chk("gap", 8'(hi), 8'h06 - 8'(dpp_pkg::REF_TAP));
		timing_in = 1'h0;
		ofs_req = 1'h1;
		repeat (30) @(posedge core_clk);
		#1;
		chk("inv", {7'h00, delayed_out}, 8'h01);
		timing_in = 1'h1; // single edge, held through the shot
		hi = 0;
		repeat (40) begin
			@(posedge core_clk);
			#1;
			if (shared_out === 1'h1) hi++;
		end
		chk("shot", 8'(hi), 8'h06);
		chk("inv2", {7'h00, delayed_out}, 8'h00);
		end_of_test();
	end
endmodule : delay_element_program_port_tb
